// ==== bus_port_monitor.sv ====
// Purpose: Pin and cycle checks on the parallel bus port
// Assumes: Latch style changes only through the plain register port
// Notes:   Bound to every port instance
`timescale 1ns/10ps
module bus_port_monitor
  import bus_port_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Register and core side
  input wire logic [3:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_write,
  input wire logic         dma_valid,
  input wire logic         dma_ready,
  input wire dma_req_type  dma_req,
  input wire logic         word_load,
  input wire logic         word_done,
  input wire logic         burst_done,
  // Pins
  input wire pins_in_type  pins_in,
  input wire pins_out_type pins_out
);
  logic        latch_q;
  logic        byte_q;
  logic [23:0] addr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Expected word address follows each completed word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_q <= 1'b0;
      byte_q  <= 1'b0;
      addr_q  <= '0;
    end
    else
    begin
      if (reg_write && reg_addr == OFF_CFG)
        latch_q <= reg_wdata[BIT_LATCH];
      if (dma_valid && dma_ready)
      begin
        addr_q <= dma_req.addr;
        byte_q <= dma_req.single_byte;
      end
      else if (word_done)
        addr_q <= addr_q + (byte_q ? 24'h1 : 24'h2);
    end
  end
  addr_phase_a: assert property (
    word_load |-> pins_out.muxed_addr_data_oe && pins_out.master_oe
      && {pins_out.upper_address, pins_out.muxed_addr_data} == addr_q)
    else $error("address phase wrong");
  strobe_phase_a: assert property (
    word_load |-> pins_out.data_strobe ##2 !pins_out.data_strobe)
    else $error("data strobe phase wrong");
  latch_low_a: assert property (
    word_load |=> !pins_out.address_pulse)
    else $error("latch output not low");
  latch_style_a: assert property (
    word_load ##2 1'b1 |-> pins_out.address_pulse == latch_q)
    else $error("latch style wrong in data portion");
  six_states_a: assert property (
    word_load |=> !word_done [*4])
    else $error("word ended too early");
  word_bound_a: assert property (
    word_load |-> ##[5:60] word_done)
    else $error("word did not end");
  read_xcvr_a: assert property (
    pins_out.master_oe && !pins_out.data_strobe && pins_out.read
      |-> !pins_out.xcvr_in_enable_n && pins_out.xcvr_out_enable_n
      && !pins_out.muxed_addr_data_oe)
    else $error("read data portion enables wrong");
  write_xcvr_a: assert property (
    pins_out.master_oe && !pins_out.data_strobe && !pins_out.read
      |-> !pins_out.xcvr_out_enable_n && pins_out.xcvr_in_enable_n)
    else $error("write data portion enables wrong");
  master_hold_a: assert property (
    pins_out.master_oe |-> pins_out.hold_request_oe)
    else $error("master outputs without hold");
  hold_release_a: assert property (
    $fell(pins_out.hold_request_oe) |-> $past(burst_done))
    else $error("hold dropped inside burst");
  slave_drive_a: assert property (
    pins_out.muxed_addr_data_oe && !pins_out.master_oe |-> pins_in.read)
    else $error("slave drove bus on write");
  cover property (word_load && pins_out.read);
  cover property (burst_done && !pins_out.read);
  cover property (pins_out.ready_oe);
endmodule // bus_port_monitor

bind lan_ctrl_parallel_bus_port bus_port_monitor bus_port_monitor_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .dma_valid(dma_valid), .dma_ready(dma_ready),
  .dma_req(dma_req), .word_load(word_load), .word_done(word_done),
  .burst_done(burst_done), .pins_in(pins_in), .pins_out(pins_out));

// ==== bus_port_pkg.sv ====
// Purpose: Shared constants and carriers for the parallel bus port
// Assumes: One T-state of the memory cycle is one clock period
// Notes:   Plain register port offsets are byte addresses

package bus_port_pkg;

  // Plain register port offsets
  localparam logic [3:0] OFF_CFG    = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_PTR    = 4'h8;

  // Indexes behind the pin-side register data port
  localparam logic [1:0] IDX_CFG    = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;

  // Fields of config_reg_three
  localparam int unsigned BIT_STYLE = 0;
  localparam int unsigned BIT_LATCH = 1;
  localparam int unsigned BIT_SWAP  = 2;
  localparam logic [2:0]  CFG_RESET = 3'h0;
  localparam logic [1:0]  PTR_RESET = 2'h0;

  // Words in one buffer burst
  localparam logic [3:0]  BURST_MAX = 4'h8;

  // Pins after synchronising; active-low pins keep their level
  typedef struct packed {
    logic        cs_n;
    logic        port_sel;
    logic        read;
    logic        data_strobe_n;
    logic        hold_grant_n;
    logic        ready_n;
    logic        request_sense;
    logic [15:0] muxed_addr_data;
  } pins_in_type;

  // Pin outputs with their enables
  typedef struct packed {
    logic [15:0] muxed_addr_data;
    logic        muxed_addr_data_oe;
    logic [7:0]  upper_address;
    logic        read;
    logic        lane_pin15;
    logic        lane_pin16;
    logic        lane_pin16_oe;
    logic        address_pulse;
    logic        data_strobe;
    logic        xcvr_out_enable_n;
    logic        xcvr_in_enable_n;
    logic        master_oe;
    logic        hold_request_oe;
    logic        ready_oe;
  } pins_out_type;

  // One DMA request from the controller core
  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        fifo;
    logic        single_byte;
    logic [3:0]  count;
  } dma_req_type;

endpackage

// ==== lan_ctrl_parallel_bus_port.sv ====
// Purpose: Parallel bus port: DMA master and register slave
// Assumes: Pins are asynchronous and pass a three-stage filter
// Notes:   Open-drain pins drive low while their enable is high
// Behaviour
// - Low 16 address bits in address portion, data in data portion.
// - Eight upper address outputs for 24-bit space, driven as master.
// - As master, direction high means memory read, low means write.
// - As slave, direction input high means device drives register data.
// - Style bit 0 picks byte masks or byte line plus grant chain.
// - Mask pair upper/lower: low/low word, low/high upper, high/low lower.
// - Byte pins driven only as master; slave accesses are full words.
// - Byte line with address bit 0 selects word, lower or upper byte.
// - Grant chain out low on grant when not requesting, else high.
// - Swap puts the most significant byte on lines 7-0.
// - Swap applies only to packet FIFO data.
// - With swap, byte line lanes for address bit 0 invert; the code inverts only the mask pair and drives address bit 0 as is.
// - Port select low is register data port, high address port.
// - Latch style clear: latch output falls in address, stays low.
// - Latch style set: latch output pulses low in address portion.
// - Data strobe high in address portion, low in data portion.
// - Outbound enable low while driving: read address only, write all.
// - Inbound enable low in read data portion, high for writes.
// - Hold request low for the whole bus transaction.
// - Reset clears style; request style needs pin sensed high first.
// - Grant low makes device master; released after request drops.
// - Master samples ready; slave asserts ready when data is ready.
// - Six T-states per cycle, waits between fourth and fifth.
// - Bursts of up to eight single-word cycles; else single cycles. The code also bursts byte requests, stepping the address by 1.
//
// The register offsets and the address-and-strobe port were left to the implementer.

`timescale 1ns/10ps

module lan_ctrl_parallel_bus_port
  import bus_port_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Plain register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [31:0]       reg_rdata,
  // DMA requests from the core
  input  wire logic         dma_valid,
  output logic              dma_ready,
  input  wire dma_req_type  dma_req,
  input  wire logic [15:0]  dma_wdata,
  output logic              word_load,
  output logic              word_done,
  output logic [15:0]       word_rdata,
  output logic              burst_done,
  // Pins
  input  wire pins_in_type  pins_in,
  output pins_out_type      pins_out
);

  typedef enum logic [3:0] {
    M_IDLE, M_REQ, M_T1, M_T2, M_T3, M_T4, M_TW, M_T5, M_T6
  } master_state_type;

  function automatic logic [15:0] swap16(input logic [15:0] w);
    swap16 = {w[7:0], w[15:8]};
  endfunction

  function automatic logic [15:0] pick_reg(input logic [1:0] idx,
                                            input logic [2:0] cfg,
                                            input logic [7:0] stat);
    case (idx)
      IDX_CFG:    pick_reg = {13'h0000, cfg};
      IDX_STATUS: pick_reg = {8'h00, stat};
      default:    pick_reg = 16'h0000;
    endcase
  endfunction

  // Three-stage pin filter
  pins_in_type s1_q, s2_q, s3_q, pin_q;
  logic [$bits(pins_in_type)-1:0] differ;
  assign differ = s2_q ^ s3_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      pin_q <= '1;
    end
    else
    begin
      s1_q  <= pins_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & ~differ) | (pin_q & differ);
    end
  end

  // Registers
  logic [2:0]  cfg_q, cfg_d;
  logic [1:0]  ptr_q, ptr_d;
  logic [7:0]  status;
  logic        style_line, latch_pulse, swap_on;

  assign style_line  = cfg_q[BIT_STYLE];
  assign latch_pulse = cfg_q[BIT_LATCH];
  assign swap_on     = cfg_q[BIT_SWAP];

  // Master state
  master_state_type state_q, state_d;
  dma_req_type      req_q, req_d;
  logic [3:0]       left_q, left_d;
  logic [15:0]      wd_q, wd_d;
  logic [15:0]      rd_q, rd_d;
  logic             req_on_q, req_on_d;
  logic             master, addr_phase, data_phase, rd_cyc, wr_cyc;
  logic             swap_eff, lane_up, grant, ready_in;

  assign grant      = ~pin_q.hold_grant_n;
  assign ready_in   = ~pin_q.ready_n;
  assign master     = (state_q != M_IDLE) && (state_q != M_REQ);
  assign addr_phase = (state_q == M_T1) || (state_q == M_T2);
  assign data_phase = master && !addr_phase;
  assign rd_cyc     = master && !req_q.write;
  assign wr_cyc     = master && req_q.write;
  assign swap_eff   = swap_on && req_q.fifo;
  assign lane_up    = req_q.addr[0] ^ swap_eff;

  assign dma_ready  = (state_q == M_IDLE);
  assign word_load  = (state_q == M_T1);
  assign word_done  = (state_q == M_T6);
  assign burst_done = word_done && (left_q == 4'h1);
  assign word_rdata = rd_q;

  // request style waits for a high pin
  logic hold_allowed;
  assign hold_allowed = !style_line || pin_q.request_sense;

  always_comb
  begin
    state_d  = state_q;
    req_d    = req_q;
    left_d   = left_q;
    wd_d     = wd_q;
    rd_d     = rd_q;
    req_on_d = req_on_q;
    case (state_q)
      M_IDLE:
        if (dma_valid)
        begin
          req_d = dma_req;
          if (dma_req.count == 4'h0)
            left_d = 4'h1;
          else if (dma_req.count > BURST_MAX)
            left_d = BURST_MAX;
          else
            left_d = dma_req.count;
          state_d = M_REQ;
        end
      M_REQ:
      begin
        if (hold_allowed)
          req_on_d = 1'b1;
        if (req_on_q && grant)
          state_d = M_T1;
      end
      M_T1:
      begin
        wd_d    = swap_eff ? swap16(dma_wdata) : dma_wdata;
        state_d = M_T2;
      end
      M_T2: state_d = M_T3;
      M_T3: state_d = M_T4;
      // waits sit between T4 and T5
      M_T4: state_d = ready_in ? M_T5 : M_TW;
      M_TW: state_d = ready_in ? M_T5 : M_TW;
      M_T5:
      begin
        if (!req_q.write)
          rd_d = swap_eff ? swap16(pin_q.muxed_addr_data)
                          : pin_q.muxed_addr_data;
        state_d = M_T6;
      end
      M_T6:
        if (left_q == 4'h1)
        begin
          req_on_d = 1'b0;
          state_d  = M_IDLE;
        end
        else
        begin
          left_d   = left_q - 4'h1;
          req_d.addr = req_q.single_byte ? req_q.addr + 24'h000001
                                         : req_q.addr + 24'h000002;
          state_d  = M_T1;
        end
      default: state_d = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= M_IDLE;
      req_q    <= '0;
      left_q   <= 4'h0;
      wd_q     <= 16'h0000;
      rd_q     <= 16'h0000;
      req_on_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      req_q    <= req_d;
      left_q   <= left_d;
      wd_q     <= wd_d;
      rd_q     <= rd_d;
      req_on_q <= req_on_d;
    end
  end

  // Slave side
  logic slave_sel, slave_strobe, slave_ack_q, slave_ack_d;
  logic slave_take, slave_rd_q, slave_rd_d;
  logic [15:0] slave_data_q, slave_data_d;
  logic pin_cfg_wr, pin_ptr_wr;

  // chip select honoured only while grant is inactive
  assign slave_sel    = !pin_q.cs_n && !grant && !master;
  assign slave_strobe = slave_sel && !pin_q.data_strobe_n;
  assign slave_take   = slave_strobe && !slave_ack_q;
  // port select picks address or data port
  assign pin_ptr_wr   = slave_take && !pin_q.read && pin_q.port_sel;
  assign pin_cfg_wr   = slave_take && !pin_q.read && !pin_q.port_sel
                        && (ptr_q == IDX_CFG);

  always_comb
  begin
    slave_ack_d  = slave_ack_q;
    slave_rd_d   = slave_rd_q;
    slave_data_d = slave_data_q;
    if (slave_take)
    begin
      slave_rd_d   = pin_q.read;
      slave_data_d = pin_q.port_sel ? {14'h0000, ptr_q}
                                    : pick_reg(ptr_q, cfg_q, status);
      slave_ack_d  = 1'b1;
    end
    // ready held until the strobe returns high
    else if (!slave_strobe)
    begin
      slave_ack_d = 1'b0;
      slave_rd_d  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_ack_q  <= 1'b0;
      slave_rd_q   <= 1'b0;
      slave_data_q <= 16'h0000;
    end
    else
    begin
      slave_ack_q  <= slave_ack_d;
      slave_rd_q   <= slave_rd_d;
      slave_data_q <= slave_data_d;
    end
  end

  // Register writes; the pin side wins a collision
  logic bus_cfg_wr, bus_ptr_wr;
  assign bus_cfg_wr = reg_write && (reg_addr == OFF_CFG);
  assign bus_ptr_wr = reg_write && (reg_addr == OFF_PTR);

  always_comb
  begin
    cfg_d = cfg_q;
    ptr_d = ptr_q;
    if (pin_cfg_wr)
      cfg_d = pin_q.muxed_addr_data[2:0];
    else if (bus_cfg_wr)
      cfg_d = reg_wdata[2:0];
    if (pin_ptr_wr)
      ptr_d = pin_q.muxed_addr_data[1:0];
    else if (bus_ptr_wr)
      ptr_d = reg_wdata[1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= CFG_RESET;
      ptr_q <= PTR_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
      ptr_q <= ptr_d;
    end
  end

  assign status = {3'h0, slave_ack_q, grant, req_on_q, master, !dma_ready};

  // Plain port read data, one cycle after the strobe
  logic [31:0] rdata_d;
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_read)
      case (reg_addr)
        OFF_CFG:    rdata_d = {29'h0000_0000, cfg_q};
        OFF_STATUS: rdata_d = {24'h00_0000, status};
        OFF_PTR:    rdata_d = {30'h0000_0000, ptr_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= rdata_d;
  end

  // Pin outputs
  logic [1:0]  lanes_n;
  logic [15:0] addr_word;
  logic        pulse_lvl, chain_out;

  // mask pair, active low per lane
  assign lanes_n = req_q.single_byte ? (lane_up ? 2'b01 : 2'b10) : 2'b00;
  // word cycles put address bit 0 low
  assign addr_word = req_q.single_byte ? req_q.addr[15:0]
                                       : {req_q.addr[15:1], 1'b0};
  // latch style: falls after T1 and stays low
  // pulse style: low only in T2
  assign pulse_lvl = latch_pulse ? (state_q != M_T2) : (state_q == M_T1);
  // grant chain follows grant when not requesting
  assign chain_out = !(grant && !req_on_q);

  always_comb
  begin
    pins_out = '0;
    // address then data on the muxed lines
    if (addr_phase)
      pins_out.muxed_addr_data = addr_word;
    else if (master)
      pins_out.muxed_addr_data = wd_q;
    else
      pins_out.muxed_addr_data = slave_data_q;
    // as master, drive while outbound enable is low; as slave, drive on register reads
    pins_out.muxed_addr_data_oe = (master && (addr_phase || wr_cyc))
                                  || (slave_ack_q && slave_rd_q);
    pins_out.upper_address = req_q.addr[23:16];
    pins_out.read          = !req_q.write;
    // pin function follows the style bit
    pins_out.lane_pin15    = style_line ? req_q.single_byte : lanes_n[0];
    pins_out.lane_pin16    = style_line ? chain_out : lanes_n[1];
    pins_out.lane_pin16_oe = style_line || master;
    pins_out.address_pulse = pulse_lvl;
    // data strobe low in data portion up to T5
    pins_out.data_strobe   = !(data_phase && (state_q != M_T6));
    pins_out.xcvr_out_enable_n = !(addr_phase || wr_cyc);
    // inbound enable in read data portion
    pins_out.xcvr_in_enable_n  = !(rd_cyc && data_phase
                                   && (state_q != M_T6));
    pins_out.master_oe     = master;
    // hold request across the whole transaction
    pins_out.hold_request_oe = req_on_q;
    pins_out.ready_oe      = slave_ack_q;
  end

endmodule // lan_ctrl_parallel_bus_port

// ==== mem_model.sv ====
// Purpose: Shared memory and bus arbiter facing the port as master
// Assumes: Sixteen words decoded from address bits 4 to 1
// Notes:   Ready comes after a set number of data portion cycles
`timescale 1ns/10ps
module mem_model
  import bus_port_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Device pins and settings
  input wire pins_out_type po,
  input wire logic [15:0]  bus,
  input wire logic [3:0]   waits,
  // Memory side
  output logic             grant_n,
  output logic             ready_n,
  output logic             drive,
  output logic [15:0]      rd_data
);
  logic [15:0] mem [16];
  logic [15:0] bus_q;
  logic [3:0]  a_q;
  logic [3:0]  cnt_q;
  logic        ap_q;
  logic        ds_q;
  wire         m = po.master_oe;
  assign ready_n = !(m && !po.data_strobe && cnt_q >= waits);
  assign drive   = m && !po.xcvr_in_enable_n;
  assign rd_data = mem[a_q];
  initial
    for (int i = 0; i < 16; i++)
      mem[i] = {4'hA, 4'(i), 4'h5, 4'(i)};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant_n <= 1'b1;
      cnt_q   <= '0;
      ap_q    <= 1'b0;
      ds_q    <= 1'b1;
    end
    else
    begin
      grant_n <= !po.hold_request_oe;
      bus_q   <= bus;
      ap_q    <= m && po.address_pulse;
      ds_q    <= !m || po.data_strobe;
      cnt_q   <= (m && !po.data_strobe) ? cnt_q + 4'h1 : 4'h0;
      if (ap_q && m && !po.address_pulse)
        a_q <= bus_q[4:1];
      if (!ds_q && m && po.data_strobe && !po.read)
        mem[a_q] <= bus_q;
    end
  end
endmodule // mem_model

// ==== tb.sv ====
// Purpose: Self-checking bench for the parallel bus port
// Assumes: Memory model answers every master cycle
// Notes:   Host slave cycles run only while the port is idle
`timescale 1ns/10ps
module tb
  import bus_port_pkg::*;
;
  logic clk, rst_n, reg_write, reg_read, dma_valid, dma_ready;
  logic word_load, word_done, burst_done, grant_n, mem_rdy_n, mem_drv;
  logic h_cs, h_sel, h_rd, h_ds, h_drv, sw;
  logic [3:0]  reg_addr, nw, waits;
  logic [31:0] reg_wdata, reg_rdata, cfg;
  logic [15:0] dma_wdata, word_rdata, bus, mem_d, h_d;
  logic [23:0] cur;
  logic [1:0]  exp_ln;
  dma_req_type  dma_req;
  pins_in_type  pins_in;
  pins_out_type pins_out;
  int n_errors, check_count, cyc;
  assign dma_wdata = {12'h3C0, nw};
  assign bus = pins_out.muxed_addr_data_oe ? pins_out.muxed_addr_data
    : mem_drv ? mem_d : h_drv ? h_d : ~pins_out.muxed_addr_data;
  assign pins_in = '{cs_n: h_cs, port_sel: h_sel,
    read: pins_out.master_oe ? pins_out.read : h_rd,
    data_strobe_n: pins_out.master_oe ? pins_out.data_strobe : h_ds,
    hold_grant_n: grant_n, ready_n: mem_rdy_n & !pins_out.ready_oe,
    request_sense: !pins_out.hold_request_oe, muxed_addr_data: bus};
  lan_ctrl_parallel_bus_port lan_ctrl_parallel_bus_port_i (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_req(dma_req),
    .dma_wdata(dma_wdata), .word_load(word_load), .word_done(word_done),
    .word_rdata(word_rdata), .burst_done(burst_done),
    .pins_in(pins_in), .pins_out(pins_out));
  mem_model mem_model_i (.clk(clk), .rst_n(rst_n), .po(pins_out),
    .bus(bus), .waits(waits), .grant_n(grant_n), .ready_n(mem_rdy_n),
    .drive(mem_drv), .rd_data(mem_d));
  function automatic logic [15:0] swp(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction
  function automatic logic [15:0] mv(input logic [3:0] i);
    return {4'hA, i, 4'h5, i};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1; cfg <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // Host cycle held until ready answers and drops again
  task slave(input logic s, r, input logic [15:0] d, e);
    @(posedge clk);
    h_cs <= 1'b0; h_sel <= s; h_rd <= r; h_d <= d; h_drv <= !r;
    h_ds <= 1'b0;
    while (pins_out.ready_oe !== 1'b1) @(negedge clk);
    if (r) chk("slave_data", e, bus);
    @(posedge clk);
    h_ds <= 1'b1; h_drv <= 1'b0;
    while (pins_out.ready_oe !== 1'b0) @(negedge clk);
    repeat (2) @(posedge clk);
    h_cs <= 1'b1; h_rd <= 1'b0;
  endtask
  task dma(input logic [23:0] a, input logic w, f, b, input logic [3:0] c,
           input logic [3:0] n, input logic [1:0] el);
    @(posedge clk);
    dma_req <= '{addr: a, write: w, fifo: f, single_byte: b, count: c};
    dma_valid <= 1'b1;
    cur = a; sw = cfg[BIT_SWAP] & f; nw = 4'h0; exp_ln = el;
    @(posedge clk);
    dma_valid <= 1'b0;
    while (burst_done !== 1'b1) @(negedge clk);
    @(negedge clk);
    chk("words", n, nw);
    for (int i = 0; i < n && w; i++)
      chk("mem", sw ? swp({12'h3C0, 4'(i)}) : {12'h3C0, 4'(i)},
          mem_model_i.mem[a[4:1] + 4'(i)]);
  endtask
  always @(negedge clk)
  begin
    if (word_load === 1'b1)
    begin
      chk("upper", cur[23:16], pins_out.upper_address);
      chk("lanes", exp_ln, {pins_out.lane_pin16, pins_out.lane_pin15});
    end
    if (word_done === 1'b1)
    begin
      if (!dma_req.write)
        chk("rdata", sw ? swp(mv(cur[4:1])) : mv(cur[4:1]), word_rdata);
      cur = cur + (dma_req.single_byte ? 24'h1 : 24'h2);
      nw = nw + 4'h1;
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      final_report;
    end
  end
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    rst_n = 0; reg_addr = 0; reg_wdata = 0; reg_write = 0; reg_read = 0;
    dma_valid = 0; dma_req = '0; h_cs = 1; h_sel = 0; h_rd = 0; h_ds = 1;
    h_drv = 0; h_d = 0; cfg = 0; waits = 0; sw = 0; nw = 0; cur = 0;
    exp_ln = 0; n_errors = 0; check_count = 0; cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_CFG, 32'(CFG_RESET));
    rd(OFF_PTR, 32'(PTR_RESET));
    rd(4'hC, 32'h0);
    rd(OFF_STATUS, 32'h0);
    slave(1'b1, 1'b0, 16'(IDX_CFG), 16'h0);
    slave(1'b0, 1'b0, 16'h0004, 16'h0);
    rd(OFF_CFG, 32'h4);
    slave(1'b0, 1'b1, 16'h0, 16'h0004);
    slave(1'b1, 1'b0, 16'(IDX_STATUS), 16'h0);
    slave(1'b0, 1'b1, 16'h0, 16'h0000);
    rd(OFF_PTR, 32'h1);
    wr(OFF_CFG, 32'h0);
    dma(24'h120004, 0, 1, 0, 4'h3, 4'h3, 2'b00);
    dma(24'h340003, 0, 0, 1, 4'h1, 4'h1, 2'b01);
    waits <= 4'h4;
    dma(24'h000010, 1, 1, 0, 4'hA, 4'h8, 2'b00);
    waits <= 4'h0;
    wr(OFF_CFG, 32'h6);
    dma(24'h560000, 0, 1, 0, 4'h2, 4'h2, 2'b00);
    dma(24'h000000, 1, 1, 0, 4'h2, 4'h2, 2'b00);
    dma(24'h000004, 1, 0, 0, 4'h1, 4'h1, 2'b00);
    dma(24'h000007, 0, 1, 1, 4'h1, 4'h1, 2'b10);
    wr(OFF_CFG, 32'h7);
    dma(24'h000009, 0, 0, 1, 4'h1, 4'h1, 2'b11);
    dma(24'h000008, 0, 0, 0, 4'h0, 4'h1, 2'b10);
    final_report;
  end
endmodule // tb
